// [brake_hold_timer.sv]
// hold timer: counts 0.1 s ticks down from a loaded duration
// assumes start is a one-cycle pulse and duration is at least one tick
`timescale 1ns/1ps
`default_nettype none
module brake_hold_timer #(
    parameter int tick_cycles = brake_seq_pkg::tick_cycles
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic stop,
    input wire logic [15:0] tenths,
    output logic done
);
    logic [23:0] tick_r, tick_nxt;
    logic [15:0] left_r, left_nxt;
    logic run_r, run_nxt;
    logic done_r, done_nxt;

    // restart reloads both counters so a late start never inherits a partial tick
    always_comb begin
        tick_nxt = tick_r;
        left_nxt = left_r;
        run_nxt = run_r;
        done_nxt = 1'b0;
        if (start) begin
            tick_nxt = 24'(tick_cycles - 1);
            left_nxt = tenths;
            run_nxt = 1'b1;
        end else if (stop) begin
            run_nxt = 1'b0;
        end else if (run_r) begin
            if (tick_r == 24'h000000) begin
                tick_nxt = 24'(tick_cycles - 1);
                if (left_r <= 16'h0001) begin
                    run_nxt = 1'b0;
                    done_nxt = 1'b1;
                end
                left_nxt = left_r - 16'h0001;
            end else begin
                tick_nxt = tick_r - 24'h000001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tick_r <= 24'h000000;
            left_r <= 16'h0000;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            tick_r <= tick_nxt;
            left_r <= left_nxt;
            run_r <= run_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule
`default_nettype wire

// [brake_seq_monitor.sv]
// checker for the stop-phase brake sequencer, bound to its top module
// assumes one clock and the synchronous active-low reset of the design
`timescale 1ns/1ps
`default_nettype none
module brake_seq_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [1:0] control_method,
    input wire logic external_brake_request,
    input wire logic dc_inject_en,
    input wire logic [4:0] dc_voltage_percent,
    input wire logic zero_speed_en,
    input wire logic servo_lock_en,
    input wire logic flux_decay_en,
    input wire logic coast,
    input wire logic brake_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic ext_r, ext_nxt, zero_r, zero_nxt, dur_wr;
    // mirror of the duration word; refused writes leave it alone
    assign dur_wr = reg_wr && reg_addr == brake_seq_pkg::addr_duration
        && (reg_wdata <= brake_seq_pkg::dur_max || reg_wdata == brake_seq_pkg::dur_code_external);
    always_comb begin
        ext_nxt = dur_wr ? reg_wdata == brake_seq_pkg::dur_code_external : ext_r;
        zero_nxt = dur_wr ? reg_wdata == 16'h0000 : zero_r;
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_r <= 1'b0;
            zero_r <= 1'b0;
        end else begin
            ext_r <= ext_nxt;
            zero_r <= zero_nxt;
        end
    end
    one_action_a: assert property ($onehot0({dc_inject_en, zero_speed_en, servo_lock_en, flux_decay_en}))
        else $error("more than one holding action");
    active_flag_a: assert property (brake_active == (dc_inject_en | zero_speed_en | servo_lock_en | flux_decay_en))
        else $error("brake_active disagrees with actions");
    volt_off_a: assert property (!dc_inject_en |-> dc_voltage_percent == 5'h00)
        else $error("voltage outside dc injection");
    volt_range_a: assert property (dc_inject_en |-> dc_voltage_percent inside {[5'h01:5'h1e]})
        else $error("dc injection voltage out of range");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data without read");
    ext_start_a: assert property (ext_r && $rose(external_brake_request) && !brake_active && !coast |=> brake_active || coast)
        else $error("external request not taken");
    ext_end_a: assert property (ext_r && !external_brake_request && brake_active |=> !brake_active)
        else $error("external hold outlived request");
    ext_zero_a: assert property (ext_r && control_method == brake_seq_pkg::ctl_sensorless && brake_active |-> zero_speed_en)
        else $error("external hold not zero speed");
    vector_act_a: assert property (control_method == brake_seq_pkg::ctl_vector && brake_active |-> zero_speed_en || servo_lock_en)
        else $error("vector hold is not zero speed or servo lock");
    zero_dur_a: assert property ($rose(brake_active) |-> !zero_r)
        else $error("hold started with zero duration");
    cover property ($rose(servo_lock_en));
    cover property ($rose(flux_decay_en));
    cover property (ext_r && $fell(brake_active));
endmodule
bind motor_stop_brake_sequencer brake_seq_monitor mon (.clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .control_method, .external_brake_request, .dc_inject_en,
    .dc_voltage_percent, .zero_speed_en, .servo_lock_en, .flux_decay_en, .coast, .brake_active);
`default_nettype wire

// [brake_seq_pkg.sv]
// constants shared by the stop-phase brake sequencer and its hold timer
// assumes one 125 MHz clock and 16-bit register data
package brake_seq_pkg;
    // register word addresses
    localparam logic [3:0] addr_start_freq = 4'h0;
    localparam logic [3:0] addr_duration = 4'h1;
    localparam logic [3:0] addr_voltage = 4'h2;
    localparam logic [3:0] addr_starting_freq = 4'h3;
    localparam logic [3:0] addr_pre_exc = 4'h4;
    localparam logic [3:0] addr_brake_op = 4'h5;
    localparam logic [3:0] addr_status = 4'h6;
    // frequency in 0.1 Hz steps, duration in 0.1 s steps
    localparam logic [15:0] freq_max = 16'h04b0;          // 120.0 Hz
    localparam logic [15:0] freq_code_starting = 16'h270f; // 9999
    localparam logic [15:0] freq_default = 16'h001e;      // 3.0 Hz
    localparam logic [15:0] freq_default_vector = 16'h0005; // 0.5 Hz
    localparam logic [15:0] starting_freq_default = 16'h0005;
    localparam logic [15:0] dur_max = 16'h0064;           // 10.0 s
    localparam logic [15:0] dur_code_external = 16'h22b8; // 8888
    localparam logic [15:0] dur_default = 16'h0005;       // 0.5 s
    localparam logic [15:0] volt_max = 16'h001e;          // 30 %
    localparam logic [15:0] volt_default = 16'h0004;      // 4 %
    localparam logic [1:0] brake_op_dc = 2'h0;
    localparam logic [1:0] brake_op_zero = 2'h1;
    localparam logic [1:0] brake_op_flux = 2'h2;
    // control methods
    localparam logic [1:0] ctl_vf = 2'h0;
    localparam logic [1:0] ctl_sensorless = 2'h1;
    localparam logic [1:0] ctl_vector = 2'h2;
    // hold timer tick
    localparam int clk_mhz = 125;
    localparam int tick_ms = 100;
    localparam int tick_cycles = tick_ms * 1000 * clk_mhz;
endpackage

// [motor_stage_model.sv]
// far-side model: output stage ramping down to stop, and the input terminal block
// assumes the bench drives stop_cmd, slow and term_req just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model #(
    parameter int term_func = 13
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic stop_cmd,
    input wire logic slow,
    input wire logic term_req,
    output logic [15:0] output_frequency,
    output logic decelerating,
    output logic external_brake_request
);
    logic [15:0] freq_r, freq_nxt;
    logic ph_r, ph_nxt;
    // one step a cycle, every other cycle when slow, to check the threshold is level based
    always_comb begin
        ph_nxt = ~ph_r;
        freq_nxt = freq_r;
        if (!stop_cmd) begin
            freq_nxt = 16'h0028;
        end else if ((!slow || ph_r) && freq_r != 16'h0000) begin
            freq_nxt = freq_r - 16'h0001;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            freq_r <= 16'h0028;
            ph_r <= 1'b0;
        end else begin
            freq_r <= freq_nxt;
            ph_r <= ph_nxt;
        end
    end
    assign output_frequency = freq_r;
    assign decelerating = stop_cmd;
    // request reaches the sequencer only through a terminal set to function 13
    assign external_brake_request = term_req && (term_func == 13);
endmodule
`default_nettype wire

// [motor_stop_brake_sequencer.sv]
// stop-phase brake sequencer: picks the holding action, when it starts and how long it lasts
// assumes synchronous inputs from the speed loop and a plain register port from software
`timescale 1ns/1ps
`default_nettype none
module motor_stop_brake_sequencer #(
    parameter int tick_cycles = brake_seq_pkg::tick_cycles,
    parameter logic [15:0] volt_reset = brake_seq_pkg::volt_default
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] output_frequency,
    input wire logic decelerating,
    input wire logic [1:0] control_method,
    input wire logic encoder_option_present,
    input wire logic external_brake_request,
    output logic dc_inject_en,
    output logic [4:0] dc_voltage_percent,
    output logic zero_speed_en,
    output logic servo_lock_en,
    output logic flux_decay_en,
    output logic coast,
    output logic brake_active
);
    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_timed = 4'b0010,
        st_external = 4'b0100,
        st_released = 4'b1000
    } seq_state_e;

    typedef enum logic [4:0] {
        act_none = 5'b00001,
        act_dc = 5'b00010,
        act_zero = 5'b00100,
        act_servo = 5'b01000,
        act_flux = 5'b10000
    } action_e;

    // settings
    logic [15:0] start_freq_r, start_freq_nxt;
    logic freq_is_default_r, freq_is_default_nxt;
    logic [15:0] duration_r, duration_nxt;
    logic [15:0] voltage_r, voltage_nxt;
    logic [15:0] starting_freq_r, starting_freq_nxt;
    logic pre_exc_r, pre_exc_nxt;
    logic [1:0] brake_op_r, brake_op_nxt;
    logic [15:0] rdata_r, rdata_nxt;

    seq_state_e state_r, state_nxt;
    action_e action_r, action_nxt;
    logic timer_start, timer_done;
    logic [15:0] threshold;
    logic dur_external;

    function automatic logic is_addr(input logic [3:0] a, input logic [3:0] b);
        is_addr = (a == b);
    endfunction

    // register writes; out-of-range values are dropped so settings stay legal
    always_comb begin
        start_freq_nxt = start_freq_r;
        freq_is_default_nxt = freq_is_default_r;
        duration_nxt = duration_r;
        voltage_nxt = voltage_r;
        starting_freq_nxt = starting_freq_r;
        pre_exc_nxt = pre_exc_r;
        brake_op_nxt = brake_op_r;
        if (reg_wr) begin
            if (is_addr(reg_addr, brake_seq_pkg::addr_start_freq) &&
                (reg_wdata <= brake_seq_pkg::freq_max ||
                 reg_wdata == brake_seq_pkg::freq_code_starting)) begin
                start_freq_nxt = reg_wdata;
                freq_is_default_nxt = 1'b0;
            end
            if (is_addr(reg_addr, brake_seq_pkg::addr_duration) &&
                (reg_wdata <= brake_seq_pkg::dur_max ||
                 reg_wdata == brake_seq_pkg::dur_code_external)) begin
                duration_nxt = reg_wdata;
            end
            if (is_addr(reg_addr, brake_seq_pkg::addr_voltage) &&
                reg_wdata <= brake_seq_pkg::volt_max) begin
                voltage_nxt = reg_wdata;
            end
            if (is_addr(reg_addr, brake_seq_pkg::addr_starting_freq) &&
                reg_wdata <= brake_seq_pkg::freq_max) begin
                starting_freq_nxt = reg_wdata;
            end
            if (is_addr(reg_addr, brake_seq_pkg::addr_pre_exc) && encoder_option_present &&
                reg_wdata <= 16'h0001) begin
                pre_exc_nxt = reg_wdata[0];
            end
            if (is_addr(reg_addr, brake_seq_pkg::addr_brake_op) &&
                reg_wdata <= 16'h0002) begin
                brake_op_nxt = reg_wdata[1:0];
            end
        end
    end

    // read data valid the cycle after the strobe only
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                brake_seq_pkg::addr_start_freq: rdata_nxt = threshold;
                brake_seq_pkg::addr_duration: rdata_nxt = duration_r;
                brake_seq_pkg::addr_voltage: rdata_nxt = voltage_r;
                brake_seq_pkg::addr_starting_freq: rdata_nxt = starting_freq_r;
                brake_seq_pkg::addr_pre_exc: rdata_nxt = {15'h0000, pre_exc_r};
                brake_seq_pkg::addr_brake_op: rdata_nxt = {14'h0000, brake_op_r};
                brake_seq_pkg::addr_status: rdata_nxt = {7'h00, action_r, state_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    // effective threshold: the default follows the control method until software writes one
    always_comb begin
        if (freq_is_default_r) begin
            threshold = (control_method == brake_seq_pkg::ctl_vector) ?
                brake_seq_pkg::freq_default_vector : brake_seq_pkg::freq_default;
        end else if (start_freq_r == brake_seq_pkg::freq_code_starting) begin
            threshold = starting_freq_r;
        end else begin
            threshold = start_freq_r;
        end
    end

    assign dur_external = (duration_r == brake_seq_pkg::dur_code_external);

    // sequence and action choice; outputs follow the registered action
    always_comb begin
        state_nxt = state_r;
        action_nxt = action_r;
        timer_start = 1'b0;
        case (state_r)
            st_idle: begin
                action_nxt = act_none;
                if (dur_external && external_brake_request) begin
                    state_nxt = st_external;
                    if (control_method == brake_seq_pkg::ctl_vector) begin
                        action_nxt = pre_exc_r ? act_servo : act_zero;
                    end else if (control_method == brake_seq_pkg::ctl_sensorless) begin
                        action_nxt = act_zero;
                    end else begin
                        action_nxt = (voltage_r == 16'h0000) ? act_none : act_dc;
                    end
                end else if (decelerating && !dur_external &&
                             output_frequency <= threshold) begin
                    if (duration_r == 16'h0000) begin
                        state_nxt = st_released;
                    end else begin
                        state_nxt = st_timed;
                        timer_start = 1'b1;
                        if (control_method == brake_seq_pkg::ctl_vector) begin
                            action_nxt = pre_exc_r ? act_servo : act_zero;
                        end else if (control_method == brake_seq_pkg::ctl_sensorless &&
                                     brake_op_r == brake_seq_pkg::brake_op_zero) begin
                            action_nxt = act_zero;
                        end else if (control_method == brake_seq_pkg::ctl_sensorless &&
                                     brake_op_r == brake_seq_pkg::brake_op_flux) begin
                            action_nxt = act_flux;
                        end else begin
                            action_nxt = (voltage_r == 16'h0000) ? act_none : act_dc;
                        end
                    end
                end
            end
            st_timed: begin
                if (timer_done) begin
                    state_nxt = st_released;
                    action_nxt = act_none;
                end
            end
            st_external: begin
                if (!external_brake_request) begin
                    state_nxt = st_idle;
                    action_nxt = act_none;
                end
            end
            st_released: begin
                // stay released until deceleration ends so one stop brakes once
                action_nxt = act_none;
                if (!decelerating) begin
                    state_nxt = st_idle;
                end
            end
            default: begin
                state_nxt = st_idle;
                action_nxt = act_none;
            end
        endcase
    end

    brake_hold_timer #(
        .tick_cycles(tick_cycles)
    ) u_timer (
        .clk(clk),
        .nrst(nrst),
        .start(timer_start),
        .stop(state_r != st_timed),
        .tenths(duration_r),
        .done(timer_done)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            start_freq_r <= brake_seq_pkg::freq_default;
            freq_is_default_r <= 1'b1;
            duration_r <= brake_seq_pkg::dur_default;
            voltage_r <= volt_reset;
            starting_freq_r <= brake_seq_pkg::starting_freq_default;
            pre_exc_r <= 1'b0;
            brake_op_r <= brake_seq_pkg::brake_op_dc;
            rdata_r <= 16'h0000;
            state_r <= st_idle;
            action_r <= act_none;
        end else begin
            start_freq_r <= start_freq_nxt;
            freq_is_default_r <= freq_is_default_nxt;
            duration_r <= duration_nxt;
            voltage_r <= voltage_nxt;
            starting_freq_r <= starting_freq_nxt;
            pre_exc_r <= pre_exc_nxt;
            brake_op_r <= brake_op_nxt;
            rdata_r <= rdata_nxt;
            state_r <= state_nxt;
            action_r <= action_nxt;
        end
    end

    // outputs registered from the next action and state; voltage forced to zero outside DC injection
    logic dc_r, zero_r, servo_r, flux_r, coast_r, active_r;
    logic [4:0] volt_out_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dc_r <= 1'b0;
            zero_r <= 1'b0;
            servo_r <= 1'b0;
            flux_r <= 1'b0;
            coast_r <= 1'b0;
            active_r <= 1'b0;
            volt_out_r <= 5'h00;
        end else begin
            dc_r <= (action_nxt == act_dc);
            zero_r <= (action_nxt == act_zero);
            servo_r <= (action_nxt == act_servo);
            flux_r <= (action_nxt == act_flux);
            coast_r <= (state_nxt == st_released) ||
                       (state_nxt != st_idle && action_nxt == act_none);
            active_r <= (action_nxt != act_none);
            volt_out_r <= (action_nxt == act_dc) ? voltage_r[4:0] : 5'h00;
        end
    end

    assign reg_rdata = rdata_r;
    assign dc_inject_en = dc_r;
    assign dc_voltage_percent = volt_out_r;
    assign zero_speed_en = zero_r;
    assign servo_lock_en = servo_r;
    assign flux_decay_en = flux_r;
    assign coast = coast_r;
    assign brake_active = active_r;
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the stop-phase brake sequencer
// assumes a 0.1 s tick shortened to 8 cycles, so one duration step is 8 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [1:0] control_method = 2'h0;
    logic encoder_option_present = 1'b0, stop_cmd = 1'b0, slow = 1'b0, term_req = 1'b0;
    logic [15:0] reg_rdata, output_frequency;
    logic decelerating, external_brake_request, dc_inject_en, zero_speed_en;
    logic servo_lock_en, flux_decay_en, coast, brake_active;
    logic [4:0] dc_voltage_percent, v_seen;
    logic [3:0] act;
    int num_errors = 0, comparisons = 0;
    always #4 clk = ~clk;
    motor_stop_brake_sequencer #(.tick_cycles(8)) uut (.clk, .nrst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .output_frequency, .decelerating, .control_method,
        .encoder_option_present, .external_brake_request, .dc_inject_en, .dc_voltage_percent,
        .zero_speed_en, .servo_lock_en, .flux_decay_en, .coast, .brake_active);
    motor_stage_model ms (.clk, .nrst, .stop_cmd, .slow, .term_req, .output_frequency,
        .decelerating, .external_brake_request);
    task stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    task chk_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        comparisons++;
        if ((v >= lo && v <= hi) !== 1'b1) begin
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
            num_errors++;
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // bounded wait; running out is a mismatch and ends the run
    task brake_wait(input int lim);
        int n;
        n = 0;
        while (brake_active !== 1'b1) begin
            @(posedge clk);
            #1 n++;
            if (n > lim) begin
                chk({15'h0000, brake_active}, 16'h0001);
                stop_test();
            end
        end
    endtask
    // one stop: frequency seen at start, hold length in cycles, coast after and release
    task run_brake(input logic [15:0] flo, input logic [15:0] fhi);
        int n;
        @(posedge clk);
        stop_cmd <= 1'b1;
        brake_wait(200);
        chk_rng(output_frequency, flo, fhi);
        act = {dc_inject_en, zero_speed_en, servo_lock_en, flux_decay_en};
        v_seen = dc_voltage_percent;
        n = 0;
        while (brake_active === 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        chk_rng(16'(n), 16'h0027, 16'h002b);
        chk({15'h0000, coast}, 16'h0001);
        @(posedge clk);
        stop_cmd <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, coast}, 16'h0000);
    endtask
    task t_regs;
        rd(4'h0, 16'h001e);
        rd(4'h1, 16'h0005);
        rd(4'h2, 16'h0004);
        rd(4'h3, 16'h0005);
        rd(4'h4, 16'h0000);
        rd(4'h5, 16'h0000);
        rd(4'h6, 16'h0011);
        rd(4'h7, 16'h0000);
        wr(4'h1, 16'h0065);
        rd(4'h1, 16'h0005);
        wr(4'h2, 16'h001f);
        rd(4'h2, 16'h0004);
        wr(4'h4, 16'h0001);
        rd(4'h4, 16'h0000);
        wr(4'h5, 16'h0003);
        rd(4'h5, 16'h0000);
        $display("test regs done");
    endtask
    task t_vector;
        @(posedge clk);
        control_method <= 2'h2;
        encoder_option_present <= 1'b1;
        rd(4'h0, 16'h0005);
        wr(4'h4, 16'h0001);
        rd(4'h4, 16'h0001);
        run_brake(16'h0003, 16'h0005);
        chk({12'h000, act}, 16'h0002);
        wr(4'h4, 16'h0000);
        run_brake(16'h0003, 16'h0005);
        chk({12'h000, act}, 16'h0004);
        $display("test vector done");
    endtask
    task t_vf;
        @(posedge clk);
        control_method <= 2'h0;
        wr(4'h2, 16'h000a);
        run_brake(16'h001c, 16'h001e);
        chk({12'h000, act}, 16'h0008);
        chk({11'h000, v_seen}, 16'h000a);
        $display("test dc injection done");
    endtask
    // zero duration, then zero voltage: no hold, motor coasts
    task t_coast;
        int n;
        for (int i = 0; i < 2; i++) begin
            if (i == 0) begin
                wr(4'h1, 16'h0000);
            end else begin
                wr(4'h1, 16'h0005);
                wr(4'h2, 16'h0000);
            end
            @(posedge clk);
            stop_cmd <= 1'b1;
            n = 0;
            repeat (60) begin
                @(posedge clk);
                #1 n += (brake_active !== 1'b0);
            end
            chk(16'(n), 16'h0000);
            chk({15'h0000, coast}, 16'h0001);
            @(posedge clk);
            stop_cmd <= 1'b0;
            repeat (2) @(posedge clk);
        end
        wr(4'h2, 16'h000a);
        $display("test coast done");
    endtask
    task t_sensorless;
        logic [3:0] exp_act[3];
        exp_act = '{4'h8, 4'h4, 4'h1};
        control_method <= 2'h1;
        for (int op = 0; op < 3; op++) begin
            wr(4'h5, 16'(op));
            run_brake(16'h001c, 16'h001e);
            chk({12'h000, act}, {12'h000, exp_act[op]});
            if (op == 1) chk({11'h000, v_seen}, 16'h0000);
        end
        $display("test sensorless done");
    endtask
    task t_external;
        // sensorless zero speed hold: operator keeps the threshold at 0.5 Hz
        wr(4'h0, 16'h0005);
        wr(4'h1, 16'h22b8);
        @(posedge clk);
        term_req <= 1'b1;
        brake_wait(5);
        chk({15'h0000, coast}, 16'h0000);
        act = {dc_inject_en, zero_speed_en, servo_lock_en, flux_decay_en};
        chk({12'h000, act}, 16'h0004);
        repeat (50) @(posedge clk);
        #1 chk({15'h0000, brake_active}, 16'h0001);
        @(posedge clk);
        term_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, brake_active}, 16'h0000);
        wr(4'h1, 16'h0005);
        $display("test external done");
    endtask
    task t_start_code;
        @(posedge clk);
        control_method <= 2'h0;
        slow <= 1'b1;
        wr(4'h3, 16'h000c);
        wr(4'h0, 16'h270f);
        rd(4'h0, 16'h000c);
        run_brake(16'h000a, 16'h000c);
        chk({12'h000, act}, 16'h0008);
        @(posedge clk);
        slow <= 1'b0;
        $display("test starting code done");
    endtask
    initial begin
        act = 4'h0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_vector();
        t_vf();
        t_coast();
        t_sensorless();
        t_external();
        t_start_code();
        stop_test();
    end
endmodule
`default_nettype wire
